// ==== hdl/cfg_loader_defs.svh ====
// address map, field positions and frame counts of the config loader
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH

`define ADDR_COMMIT      12'h232
`define ADDR_LIST_LO     12'hA00
`define ADDR_LIST_HI     12'hAFF
`define ADDR_NVM_STATUS  12'hB00
`define ADDR_NVM_SAVE    12'hB03
`define BIT_COMMIT       0
`define BIT_SAVE         0
`define BIT_BUSY         0
`define CMD_OP_BIT       7
`define LIST_BYTES       256
`define LIST_LAST        8'hFF
`define OP_COMMIT_DEF    8'h81
`define OP_END_DEF       8'h80
`define FRAME_INSTR_LAST 5'h0F
`define FRAME_LAST       5'h17
`define INSTR_RW_BIT     15

`endif

// ==== hdl/cfg_loader_pkg.sv ====
// shared types of the config loader
`default_nettype none
package cfg_loader_pkg;

    // command list walker states
    typedef enum logic [4:0] {
        W_IDLE = 5'b00001,
        W_CMD  = 5'b00010,
        W_ADRH = 5'b00100,
        W_ADRL = 5'b01000,
        W_DATA = 5'b10000
    } walk_e;

    // one register byte on its way to nonvolatile memory
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } nvm_byte_s;

endpackage : cfg_loader_pkg
`default_nettype wire

// ==== hdl/nvm_fifo.sv ====
// shift fifo with registered head between walker and nvm write port
`timescale 1ns/100ps
`default_nettype none
module nvm_fifo
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
)
(
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1)
        $error("nvm_fifo: DEPTH must be at least 2");

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0]               cnt;
        logic                        full;
        logic                        nempty;
    } fifo_s;

    fifo_s s_q;
    fifo_s s_d;
    logic  push;
    logic  pop;
    logic [CW-1:0] wr_at;

    // shift out at the head, write behind the last entry
    always_comb
    begin
        s_d   = s_q;
        pop   = s_q.nempty && out_ready_in;
        push  = in_valid_in && !s_q.full;
        wr_at = s_q.cnt;
        if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                s_d.mem[i] = s_q.mem[i + 1];
            wr_at = s_q.cnt - CW'(1);
        end
        if (push)
            s_d.mem[wr_at] = in_data_in;
        s_d.cnt    = s_q.cnt + CW'(push) - CW'(pop);
        s_d.full   = (s_d.cnt == CW'(DEPTH));
        s_d.nempty = (s_d.cnt != '0);
    end

    // state register
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign in_ready_out  = !s_q.full;
    assign out_valid_out = s_q.nempty;
    assign out_data_out  = s_q.mem[0];
endmodule : nvm_fifo
`default_nettype wire

// ==== hdl/cfg_loader.sv ====
// register commit and nvm command list walker behind the serial port
// Functional notes
// - writing one to commit bit copies buffered registers to active
// - the copy happens on the next serial clock rising edge
// - the commit bit clears itself after the copy
// - command list bytes live at 0xA00 to 0xAFF
// - command byte with top bit zero is a data transfer entry
// - low seven bits hold byte count minus one
// - next two list bytes hold start address, high byte first
// - start address and count select which registers are moved
// - command byte with top bit one is an operation code
// - commit operation code copies buffered to active registers, except at 0xAFF where it only stops the transfer
// - end of data operation code stops the transfer
// - reset list moves every register, then commits
// - self-clearing save bit starts the save walk
// - read-only busy bit is one while a transfer runs
`timescale 1ns/100ps
`default_nettype none
`include "cfg_loader_defs.svh"
module cfg_loader
    import cfg_loader_pkg::*;
#(
    parameter int         CFG_BYTES  = 64,
    parameter logic [7:0] OP_COMMIT  = `OP_COMMIT_DEF,
    parameter logic [7:0] OP_END     = `OP_END_DEF,
    parameter int         FIFO_DEPTH = 4
)
(
    input  wire logic                   clk_in,
    input  wire logic                   nrst_in,
    input  wire logic                   sclk_in,
    input  wire logic                   csb_n_in,
    input  wire logic                   sdi_in,
    output logic                        sdo_out,
    output logic                        sdo_oe_out,
    input  wire logic                   nvm_load_in,
    output logic                        nvm_wr_valid_out,
    output nvm_byte_s                   nvm_wr_data_out,
    input  wire logic                   nvm_wr_ready_in,
    input  wire logic                   nvm_rd_valid_in,
    input  wire logic [7:0]             nvm_rd_data_in,
    output logic                        nvm_rd_ready_out,
    output logic [CFG_BYTES-1:0][7:0]   active_cfg_out
);
    localparam int IW = (CFG_BYTES > 1) ? $clog2(CFG_BYTES) : 1;

    // codes must differ in the low seven bits
    if (CFG_BYTES < 1 || CFG_BYTES > 128 ||
        OP_COMMIT[6:0] == OP_END[6:0] ||
        !OP_COMMIT[`CMD_OP_BIT] || !OP_END[`CMD_OP_BIT])
        $error("cfg_loader: unusable parameters");

    typedef logic [`LIST_BYTES-1:0][7:0] list_t;

    // one entry over the whole bank, commit, then end codes
    function automatic list_t default_list();
        list_t l;
        for (int i = 0; i < `LIST_BYTES; i++)
            l[i] = OP_END;
        l[0] = {1'b0, 7'(CFG_BYTES - 1)};
        l[1] = 8'h00;
        l[2] = 8'h00;
        l[3] = OP_COMMIT;
        return l;
    endfunction : default_list

    typedef struct packed {
        logic [2:0]                 sclk_sy;
        logic [2:0]                 csb_sy;
        logic [1:0]                 sdi_sy;
        logic [2:0]                 load_sy;
        logic [4:0]                 bitcnt;
        logic [14:0]                shreg;
        logic                       rw;
        logic [11:0]                raddr;
        logic [7:0]                 rdata;
        logic                       sdo;
        logic                       sdo_oe;
        logic                       commit_pend;
        walk_e                      walk;
        logic                       load_dir;
        logic [7:0]                 idx;
        logic [6:0]                 len;
        logic [15:0]                addr;
        logic                       rd_ready;
        logic [CFG_BYTES-1:0][7:0]  buffer;
        logic [CFG_BYTES-1:0][7:0]  active;
        list_t                      list;
    } state_s;

    localparam state_s RESET_STATE = '{
        walk: W_IDLE, list: default_list(), csb_sy: 3'h7, default: '0};

    state_s    s_q;
    state_s    s_d;
    logic      sclk_rise;
    logic      sclk_fall;
    logic      csb_low;
    logic      sdi_bit;
    logic      load_rise;
    logic      wr_strobe;
    logic      commit_set;
    logic      save_set;
    logic [7:0] wr_byte;
    logic [15:0] instr;
    logic [7:0] cur;
    logic      in_bank;
    logic [IW-1:0] bidx;
    logic      push_valid;
    logic      push_ready;
    logic      take_rd;
    nvm_byte_s push_data;

    // edges of the synchronised pins, read from the second stage onward
    assign sclk_rise = s_q.sclk_sy[1] && !s_q.sclk_sy[2];
    assign sclk_fall = !s_q.sclk_sy[1] && s_q.sclk_sy[2];
    assign csb_low   = !s_q.csb_sy[1];
    assign sdi_bit   = s_q.sdi_sy[1];
    assign load_rise = s_q.load_sy[1] && !s_q.load_sy[2];
    assign instr     = {s_q.shreg, sdi_bit};
    assign wr_byte   = {s_q.shreg[6:0], sdi_bit};
    assign wr_strobe = sclk_rise && csb_low && !s_q.rw &&
                       s_q.bitcnt == `FRAME_LAST;
    assign commit_set = wr_strobe && s_q.raddr == `ADDR_COMMIT &&
                        wr_byte[`BIT_COMMIT];
    assign save_set   = wr_strobe && s_q.raddr == `ADDR_NVM_SAVE &&
                        wr_byte[`BIT_SAVE];
    assign cur       = s_q.list[s_q.idx];
    assign in_bank   = s_q.addr < 16'(CFG_BYTES);
    assign bidx      = s_q.addr[IW-1:0];
    assign take_rd   = s_q.walk == W_DATA && s_q.load_dir &&
                       s_q.rd_ready && nvm_rd_valid_in;
    assign push_valid = s_q.walk == W_DATA && !s_q.load_dir;
    assign push_data  = '{addr: s_q.addr,
                          data: in_bank ? s_q.buffer[bidx] : 8'h00};

    // serial port, commit and command list walker
    always_comb
    begin
        s_d = s_q;
        s_d.sclk_sy = {s_q.sclk_sy[1:0], sclk_in};
        s_d.csb_sy  = {s_q.csb_sy[1:0], csb_n_in};
        s_d.sdi_sy  = {s_q.sdi_sy[0], sdi_in};
        s_d.load_sy = {s_q.load_sy[1:0], nvm_load_in};
        if (!csb_low)
        begin
            s_d.bitcnt = '0;
            s_d.sdo_oe = 1'b0;
        end
        else if (sclk_rise)
        begin
            s_d.shreg  = instr[14:0];
            s_d.bitcnt = (s_q.bitcnt == `FRAME_LAST) ? '0
                                                     : s_q.bitcnt + 5'h01;
            if (s_q.bitcnt == `FRAME_INSTR_LAST)
            begin
                s_d.rw     = instr[`INSTR_RW_BIT];
                s_d.raddr  = instr[11:0];
                s_d.sdo_oe = instr[`INSTR_RW_BIT];
                s_d.rdata  = 8'h00;
                if (instr[11:0] == `ADDR_COMMIT)
                    s_d.rdata[`BIT_COMMIT] = s_q.commit_pend;
                else if (instr[11:0] == `ADDR_NVM_STATUS ||
                         instr[11:0] == `ADDR_NVM_SAVE)
                    s_d.rdata[`BIT_BUSY] = s_q.walk != W_IDLE;
                else if (instr[11:0] >= `ADDR_LIST_LO &&
                         instr[11:0] <= `ADDR_LIST_HI)
                    s_d.rdata = s_q.list[instr[7:0]];
                else if (instr[11:0] < 12'(CFG_BYTES))
                    s_d.rdata = s_q.buffer[instr[IW-1:0]];
            end
            if (s_q.bitcnt == `FRAME_LAST)
                s_d.sdo_oe = 1'b0;
        end
        else if (sclk_fall && s_q.sdo_oe)
        begin
            s_d.sdo   = s_q.rdata[7];
            s_d.rdata = {s_q.rdata[6:0], 1'b0};
        end
        // register writes from the host
        if (wr_strobe)
        begin
            if (s_q.raddr >= `ADDR_LIST_LO && s_q.raddr <= `ADDR_LIST_HI)
                s_d.list[s_q.raddr[7:0]] = wr_byte;
            else if (s_q.raddr < 12'(CFG_BYTES))
                s_d.buffer[s_q.raddr[IW-1:0]] = wr_byte;
        end
        // copy waits for the next serial clock rise, then clears itself
        if (s_q.commit_pend && sclk_rise)
        begin
            s_d.active      = s_q.buffer;
            s_d.commit_pend = 1'b0;
        end
        if (commit_set)
            s_d.commit_pend = 1'b1;
        // walker
        case (s_q.walk)
            W_IDLE:
            begin
                s_d.idx = 8'h00;
                if (save_set || load_rise)
                begin
                    s_d.walk     = W_CMD;
                    s_d.load_dir = !save_set;
                end
            end
            W_CMD:
            begin
                s_d.idx = s_q.idx + 8'h01;
                if (!cur[`CMD_OP_BIT])
                begin
                    s_d.len  = cur[6:0];
                    s_d.walk = W_ADRH;
                end
                else if (cur == OP_COMMIT && s_q.idx != `LIST_LAST)
                    s_d.active = s_q.buffer;
                else
                    s_d.walk = W_IDLE;
            end
            W_ADRH:
            begin
                s_d.addr[15:8] = cur;
                s_d.idx        = s_q.idx + 8'h01;
                s_d.walk       = W_ADRL;
            end
            W_ADRL:
            begin
                s_d.addr[7:0] = cur;
                s_d.idx       = s_q.idx + 8'h01;
                s_d.walk      = W_DATA;
            end
            W_DATA:
            begin
                if ((push_valid && push_ready) || take_rd)
                begin
                    if (take_rd && in_bank)
                        s_d.buffer[bidx] = nvm_rd_data_in;
                    s_d.addr = s_q.addr + 16'h0001;
                    s_d.len  = s_q.len - 7'h01;
                    if (s_q.len == 7'h00)
                        s_d.walk = W_CMD;
                end
            end
            default:
                s_d.walk = W_IDLE;
        endcase
        s_d.rd_ready = s_d.walk == W_DATA && s_d.load_dir;
    end

    // state register
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            s_q <= RESET_STATE;
        else
            s_q <= s_d;
    end

    // save path toward the nvm write port
    nvm_fifo #(
        .WIDTH ($bits(nvm_byte_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (push_valid),
        .in_data_in    (push_data),
        .in_ready_out  (push_ready),
        .out_valid_out (nvm_wr_valid_out),
        .out_data_out  (nvm_wr_data_out),
        .out_ready_in  (nvm_wr_ready_in)
    );

    assign sdo_out          = s_q.sdo;
    assign sdo_oe_out       = s_q.sdo_oe;
    assign nvm_rd_ready_out = s_q.rd_ready;
    assign active_cfg_out   = s_q.active;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_entry_cmd;
        s_q.walk == W_CMD && !cur[`CMD_OP_BIT];
    endsequence
    sequence s_addr_hi;
        s_q.walk == W_ADRH;
    endsequence

    chk_commit_set: assert property (commit_set |=> s_q.commit_pend)
        else $error("commit write did not arm the copy");
    chk_commit_copy: assert property (s_q.commit_pend && sclk_rise
        |=> s_q.active == $past(s_q.buffer))
        else $error("commit copy missing on serial clock rise");
    chk_commit_clear: assert property (
        s_q.commit_pend && sclk_rise && !commit_set |=> !s_q.commit_pend)
        else $error("commit bit did not clear itself");
    chk_entry_len: assert property (s_entry_cmd
        |=> s_q.walk == W_ADRH && s_q.len == $past(cur[6:0]))
        else $error("data entry length not taken");
    chk_addr_order: assert property (s_entry_cmd ##1 s_addr_hi
        |=> s_q.addr[15:8] == $past(cur) ##1
            s_q.walk == W_DATA && s_q.addr[7:0] == $past(cur))
        else $error("start address not loaded high byte first");
    chk_end_stop: assert property (
        s_q.walk == W_CMD && cur == OP_END |=> s_q.walk == W_IDLE)
        else $error("end code did not stop the walk");
    chk_op_commit: assert property (s_q.walk == W_CMD &&
        cur == OP_COMMIT && s_q.idx != `LIST_LAST
        |=> s_q.active == $past(s_q.buffer) && s_q.walk == W_CMD)
        else $error("commit code did not copy registers");
    chk_save_start: assert property (s_q.walk == W_IDLE && save_set
        |=> s_q.walk == W_CMD && !s_q.load_dir && s_q.idx == 8'h00)
        else $error("save bit did not start the walk");
    chk_data_step: assert property (s_q.walk == W_DATA &&
        (take_rd || (push_valid && push_ready))
        |=> s_q.addr == $past(s_q.addr) + 16'h0001)
        else $error("data address did not advance by one");
endmodule : cfg_loader
`default_nettype wire

// ==== bench/serial_host.sv ====
// serial port host model that frames register reads and writes
`timescale 1ns/100ps
`default_nettype none
module serial_host
(
    output logic      sclk_out,
    output logic      csb_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    // link clock rests low and select high outside frames
    initial
    begin
        sclk_out = 1'b0;
        csb_n_out = 1'b1;
        sdi_out = 1'b0;
    end

    // one frame: rw, three spare bits, address, data, msb first
    task automatic xfer(input logic rd, input logic [11:0] addr,
                        input logic [7:0] wdat, output logic [7:0] rdat);
        logic [23:0] word;
        word = {rd, 3'h0, addr, wdat};
        rdat = 8'h00;
        csb_n_out = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sdi_out = word[i];
            #62.5 sclk_out = 1'b1;
            if (i < 8)
                rdat[i] = sdo_in; // sampled on the rising link edge
            #62.5 sclk_out = 1'b0;
        end
        #62.5 csb_n_out = 1'b1;
        sdi_out = ~sdi_out; // idle data line shows no stale bit
        #125;
    endtask : xfer
endmodule : serial_host
`default_nettype wire

// ==== bench/cfg_loader_bench.sv ====
// self-checking bench for register commit and nvm list walker
`timescale 1ns/100ps
`default_nettype none
module cfg_loader_bench
    import cfg_loader_pkg::*;
;
    localparam int NB = 64;
    logic               clk_in, nrst_in, sclk, csb_n, sdi, sdo, sdo_oe;
    logic               load, wr_valid, wr_ready, rd_valid, rd_ready;
    nvm_byte_s          wr_data;
    logic [7:0]         rd_data;
    logic               sdo_pin;
    logic [NB-1:0][7:0] active;
    logic [7:0]         exp_buf [NB];
    logic [23:0]        pushes [$];
    int                 err_count, total_checks;

    // 100 MHz system clock
    initial
        clk_in = 1'b0;
    always #5 clk_in = ~clk_in;

    // released line shows the inverse of the held bit
    assign sdo_pin = sdo_oe ? sdo : ~sdo;

    cfg_loader #(.CFG_BYTES(NB), .FIFO_DEPTH(4)) dut
    (
        .clk_in           (clk_in),
        .nrst_in          (nrst_in),
        .sclk_in          (sclk),
        .csb_n_in         (csb_n),
        .sdi_in           (sdi),
        .sdo_out          (sdo),
        .sdo_oe_out       (sdo_oe),
        .nvm_load_in      (load),
        .nvm_wr_valid_out (wr_valid),
        .nvm_wr_data_out  (wr_data),
        .nvm_wr_ready_in  (wr_ready),
        .nvm_rd_valid_in  (rd_valid),
        .nvm_rd_data_in   (rd_data),
        .nvm_rd_ready_out (rd_ready),
        .active_cfg_out   (active)
    );

    serial_host u_host
    (
        .sclk_out  (sclk),
        .csb_n_out (csb_n),
        .sdi_out   (sdi),
        .sdo_in    (sdo_pin)
    );

    // record every byte the nvm side accepts
    always @(posedge clk_in)
        if (nrst_in === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1)
            pushes.push_back(wr_data);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer(1'b0, a, d, r);
        if (a < NB)
            exp_buf[a] = d;
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer(1'b1, a, 8'h00, r);
        check(r, e);
        check(sdo_oe, 1'b0);
    endtask : rd_chk

    // bounded wait for n accepted nvm bytes
    task automatic wait_pushes(input int n);
        int k;
        k = 0;
        while (pushes.size() < n && k < 5000)
        begin
            @(posedge clk_in);
            k++;
        end
        if (pushes.size() < n)
        begin
            err_count++;
            end_sim();
        end
    endtask : wait_pushes

    // offer one restore byte and hold it until taken
    task automatic feed(input logic [7:0] b);
        int k;
        @(posedge clk_in);
        rd_valid <= 1'b1;
        rd_data <= b;
        k = 0;
        do
        begin
            @(negedge clk_in);
            k++;
        end
        while (rd_ready !== 1'b1 && k < 200);
        @(posedge clk_in);
        rd_valid <= 1'b0;
        rd_data <= ~b; // released data shows no stale byte
        if (k == 200)
        begin
            err_count++;
            end_sim();
        end
    endtask : feed

    task automatic t_reset();
        rd_chk(12'hA00, 8'h3F);
        rd_chk(12'hA01, 8'h00);
        rd_chk(12'hA02, 8'h00);
        rd_chk(12'hA03, 8'h81);
        rd_chk(12'hA04, 8'h80);
        rd_chk(12'hB00, 8'h00);
        check(active[0], 8'h00);
    endtask : t_reset

    task automatic t_commit();
        wr(12'h000, 8'h5A);
        wr(12'h03F, 8'hC3);
        wr(12'h232, 8'h01);
        repeat (20) @(posedge clk_in);
        check(active[0], 8'h00);
        rd_chk(12'h232, 8'h00);
        check(active[0], 8'h5A);
        check(active[63], 8'hC3);
        wr(12'hB01, 8'hFF);
        rd_chk(12'hB01, 8'h00);
        wr(12'hB00, 8'h01);
        rd_chk(12'hB00, 8'h00);
    endtask : t_commit

    // default list with the nvm side stalled, then drained
    task automatic t_save_default();
        pushes.delete();
        wr(12'h001, 8'h77);
        wr(12'hB03, 8'h01);
        rd_chk(12'hB00, 8'h01);
        check(wr_valid, 1'b1);
        check(pushes.size(), 0);
        @(posedge clk_in);
        wr_ready <= 1'b1;
        wait_pushes(NB);
        for (int i = 0; i < NB; i++)
            check(pushes[i], {i[15:0], exp_buf[i]});
        rd_chk(12'hB00, 8'h00);
        rd_chk(12'hB03, 8'h00);
        check(active[1], 8'h77);
    endtask : t_save_default

    // own list: two-byte entry, out-of-bank entry, commit, end
    task automatic t_custom();
        wr(12'hA00, 8'h01);
        wr(12'hA01, 8'h00);
        wr(12'hA02, 8'h10);
        wr(12'hA03, 8'h00);
        wr(12'hA04, 8'h00);
        wr(12'hA05, 8'h40);
        wr(12'hA06, 8'h81);
        wr(12'hA07, 8'h80);
        wr(12'hAFF, 8'h80);
        wr(12'h010, 8'h11);
        wr(12'h011, 8'h22);
        repeat (1000) @(posedge clk_in);
        pushes.delete();
        wr(12'hB03, 8'h01);
        wait_pushes(3);
        repeat (50) @(posedge clk_in);
        check(pushes.size(), 3);
        check(pushes[0], 24'h001011);
        check(pushes[1], 24'h001122);
        check(pushes[2], 24'h004000);
        check(active[16], 8'h11);
        repeat (1000) @(posedge clk_in);
        load <= 1'b1;
        repeat (4) @(posedge clk_in);
        load <= 1'b0;
        feed(8'hA1);
        feed(8'hA2);
        feed(8'hA3);
        repeat (20) @(posedge clk_in);
        check(active[16], 8'hA1);
        check(active[17], 8'hA2);
        check(active[0], 8'h5A);
        rd_chk(12'h010, 8'hA1);
        rd_chk(12'hB00, 8'h00);
    endtask : t_custom

    // reset, then the scenarios in order
    initial
    begin
        nrst_in = 1'b0;
        load = 1'b0;
        wr_ready = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
        err_count = 0;
        total_checks = 0;
        foreach (exp_buf[i])
            exp_buf[i] = 8'h00;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        t_reset();
        t_commit();
        t_save_default();
        t_custom();
        end_sim();
    end
endmodule : cfg_loader_bench
`default_nettype wire
